// ### hw/sbp_partition_regs.sv
// Socket buffer partition register bank: per-socket transmit and receive
// sizes, the block direction map and the PPP session parameters.
// Assumes a same-clock master on the plain register port and a PPP engine
// on core_clk_i that reports authentication type and session id.
//
// Functional notes
// RULE1 - Eight sockets, each size zero to 64 KB.
// RULE2 - Every size field resets to eight.
// RULE3 - Software keeps transmit total a multiple of eight.
// RULE4 - Software keeps both totals summing to 128 KB.
// RULE5 - Even socket upper byte, odd socket lower.
// RULE6 - Sixteen 8 KB blocks, one map bit each.
// RULE7 - Map bit one transmit, zero receive.
// RULE8 - Software sets transmit bits contiguously from zero.
// RULE9 - Direction map resets to 0x00ff.
// RULE10 - Read-only authentication code, PAP or CHAP.
// RULE11 - Echo requests every interval of 25 ms ticks.
// RULE12 - Magic number is the seed byte repeated.
// RULE13 - Read-only session identifier, resets to zero.
`timescale 1ns/1ps
module sbp_partition_regs #(
   // Cycles in one 25 ms echo tick; shorten in simulation.
   parameter int unsigned ECHO_TICK_CYCLES = `SBP_ECHO_TICK_MS * `SBP_CLK_KHZ
) (
   // Clock and reset.
   input  wire logic                 core_clk_i,
   input  wire logic                 srst_i,
   // Register port.
   input  wire sbp_pkg::sbp_addr_type reg_addr_i,
   input  wire sbp_pkg::sbp_word_type reg_wdata_i,
   input  wire logic                 reg_wr_i,
   input  wire logic                 reg_rd_i,
   output sbp_pkg::sbp_word_type     reg_rdata_o,
   // PPP engine reports.
   input  wire logic                 ppp_auth_load_i,
   input  wire sbp_pkg::sbp_word_type ppp_auth_code_i,
   input  wire logic                 ppp_session_load_i,
   input  wire sbp_pkg::sbp_word_type ppp_session_id_i,
   input  wire logic                 ppp_link_open_i,
   // Partition outputs to the buffer manager.
   output logic [63:0]               tx_size_o,
   output logic [63:0]               rx_size_o,
   output logic [15:0]               block_is_tx_o,
   // PPP engine controls.
   output logic [31:0]               magic_number_o,
   output logic                      echo_req_o,
   output logic                      config_ok_o
);
   import sbp_pkg::*;

   // Size pair registers, index 0 holds sockets 0 and 1.
   sbp_word_type   tx_size_q [4];
   sbp_word_type   rx_size_q [4];
   // Direction map, bit n describes block n.
   sbp_word_type   block_map_q;
   // Values reported by the PPP engine.
   sbp_auth_type   auth_q;
   sbp_word_type   session_q;
   // Software settings for the PPP engine.
   logic [7:0]     echo_interval_q;
   logic [7:0]     magic_q;
   // Read data and its next value.
   sbp_word_type   rdata_q;
   sbp_word_type   rdata_d;
   // Totals from the two adders.
   sbp_kb_sum_type tx_total_kb;
   sbp_kb_sum_type rx_total_kb;
   logic           tx_range_ok;
   logic           rx_range_ok;
   // Consistency checks.
   logic           tx_aligned;
   logic           total_ok;
   logic           map_ok;
   // Flattened size pairs, pair 0 in the low word.
   logic [63:0]    tx_pairs;
   logic [63:0]    rx_pairs;
   // Write to the echo interval, restarts the timer.
   logic           echo_wr;

   // True when addr hits pair idx above base.
   function automatic logic sbp_pair_hit(input sbp_addr_type addr,
                                         input sbp_addr_type base,
                                         input logic [1:0]   idx);
      return addr == base + sbp_addr_type'({idx, 1'b0});
   endfunction : sbp_pair_hit

   // Swaps a pair word into socket order: even socket
   // moves from the upper to the lower byte.
   function automatic logic [15:0] sbp_socket_order(input sbp_word_type w);
      return {w[7:0], w[15:8]};
   endfunction : sbp_socket_order

   // Mask of the map that a given transmit total implies.
   function automatic sbp_word_type sbp_expected_map(input sbp_kb_sum_type kb);
      sbp_word_type m;
      m = '0;
      for (int i = 0; i < 16; i++) begin
         if (sbp_kb_sum_type'(i) < (kb >> 3)) begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction : sbp_expected_map

   // Transmit size pairs. Each byte is stored as written; values above 64
   // are kept, so software can read back its mistake, and flagged in status.
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         for (int i = 0; i < 4; i++) begin
            tx_size_q[i] <= `SBP_RST_SIZE_PAIR;  // see RULE2
         end
      end else if (reg_wr_i) begin
         for (int i = 0; i < 4; i++) begin
            if (sbp_pair_hit(reg_addr_i, `SBP_OFS_TX_SIZE_01, 2'(i))) begin
               tx_size_q[i] <= reg_wdata_i;  // see RULE1
            end
         end
      end
   end

   // Receive size pairs, laid out like the transmit ones.
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         for (int i = 0; i < 4; i++) begin
            rx_size_q[i] <= `SBP_RST_SIZE_PAIR;  // see RULE2
         end
      end else if (reg_wr_i) begin
         for (int i = 0; i < 4; i++) begin
            if (sbp_pair_hit(reg_addr_i, `SBP_OFS_RX_SIZE_01, 2'(i))) begin
               rx_size_q[i] <= reg_wdata_i;  // see RULE1
            end
         end
      end
   end

   // Direction map takes any pattern; the contiguity check only
   // reports, since blocking writes would trap software mid-way
   // through an intermediate pattern.
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         block_map_q <= `SBP_RST_BLOCK_MAP;  // see RULE9
      end else if (reg_wr_i && reg_addr_i == `SBP_OFS_BLOCK_MAP) begin
         block_map_q <= reg_wdata_i;  // see RULE6
      end
   end

   // Authentication code, loaded only by the PPP engine.
   // Codes are not filtered here.
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         auth_q <= SBP_AUTH_NONE_CODE;  // see RULE10
      end else if (ppp_auth_load_i) begin
         auth_q <= sbp_auth_type'(ppp_auth_code_i);  // see RULE10
      end
   end

   // Session identifier, written only by the PPP engine after discovery.
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         session_q <= `SBP_RST_SESSION;  // see RULE13
      end else if (ppp_session_load_i) begin
         session_q <= ppp_session_id_i;  // see RULE13
      end
   end

   // Echo interval; the upper byte is reserved and not stored.
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         echo_interval_q <= `SBP_RST_ECHO_INTERVAL;  // see RULE11
      end else if (echo_wr) begin
         echo_interval_q <= reg_wdata_i[7:0];  // see RULE11
      end
   end

   assign echo_wr = reg_wr_i && reg_addr_i == `SBP_OFS_ECHO_INTERVAL;

   // Magic seed byte; the upper byte is reserved and not stored.
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         magic_q <= `SBP_RST_MAGIC;  // see RULE12
      end else if (reg_wr_i && reg_addr_i == `SBP_OFS_MAGIC_SEED) begin
         magic_q <= reg_wdata_i[7:0];
      end
   end

   // Flatten the pairs for the transmit and receive adders.
   always_comb begin
      tx_pairs = '0;
      rx_pairs = '0;
      for (int i = 0; i < 4; i++) begin
         tx_pairs[16*i +: 16] = tx_size_q[i];
         rx_pairs[16*i +: 16] = rx_size_q[i];
      end
   end

   // Transmit total and range check.
   sbp_size_sum u_tx_sum (
      .core_clk_i   (core_clk_i),
      .srst_i       (srst_i),
      .size_pairs_i (tx_pairs),
      .sum_kb_o     (tx_total_kb),
      .range_ok_o   (tx_range_ok)
   );

   // Receive total and range check.
   sbp_size_sum u_rx_sum (
      .core_clk_i   (core_clk_i),
      .srst_i       (srst_i),
      .size_pairs_i (rx_pairs),
      .sum_kb_o     (rx_total_kb),
      .range_ok_o   (rx_range_ok)
   );

   // Software owns alignment, total and contiguity;
   // these checks only make a violation visible.
   assign tx_aligned = (tx_total_kb[2:0] == 3'h0);  // see RULE3
   assign total_ok   = (tx_total_kb + rx_total_kb == `SBP_TOTAL_KB);  // see RULE4
   assign map_ok     = (block_map_q == sbp_expected_map(tx_total_kb));  // see RULE8

   // Read multiplexer. Reserved bytes and unmapped addresses read
   // zero; status is a live view of the checks.
   always_comb begin
      rdata_d = '0;
      for (int i = 0; i < 4; i++) begin
         if (sbp_pair_hit(reg_addr_i, `SBP_OFS_TX_SIZE_01, 2'(i))) begin
            rdata_d = tx_size_q[i];  // see RULE5
         end
         if (sbp_pair_hit(reg_addr_i, `SBP_OFS_RX_SIZE_01, 2'(i))) begin
            rdata_d = rx_size_q[i];  // see RULE5
         end
      end
      unique case (reg_addr_i)
         `SBP_OFS_BLOCK_MAP: begin
            rdata_d = block_map_q;
         end
         `SBP_OFS_AUTH_TYPE: begin
            rdata_d = auth_q;
         end
         `SBP_OFS_ECHO_INTERVAL: begin
            rdata_d = {8'h00, echo_interval_q};
         end
         `SBP_OFS_MAGIC_SEED: begin
            rdata_d = {8'h00, magic_q};
         end
         `SBP_OFS_SESSION_ID: begin
            rdata_d = session_q;
         end
         `SBP_OFS_CFG_STATUS: begin
            rdata_d[`SBP_STAT_TX_ALIGNED] = tx_aligned;
            rdata_d[`SBP_STAT_TOTAL_OK]   = total_ok;
            rdata_d[`SBP_STAT_MAP_OK]     = map_ok;
            rdata_d[`SBP_STAT_RANGE_OK]   = tx_range_ok & rx_range_ok;
         end
         default: begin
            // Size pairs were handled above; anything else stays zero.
         end
      endcase
   end

   // Read data stand only in the cycle after the read strobe, and are zero
   // otherwise, so a stale word is never mistaken for an answer.
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= reg_rd_i ? rdata_d : '0;
      end
   end

   assign reg_rdata_o = rdata_q;

   // Registered partition outputs, socket n in byte n of each vector.
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         tx_size_o     <= {4{`SBP_RST_SIZE_PAIR}};
         rx_size_o     <= {4{`SBP_RST_SIZE_PAIR}};
         block_is_tx_o <= `SBP_RST_BLOCK_MAP;
      end else begin
         for (int i = 0; i < 4; i++) begin
            tx_size_o[16*i +: 16] <= sbp_socket_order(tx_size_q[i]);  // see RULE5
            rx_size_o[16*i +: 16] <= sbp_socket_order(rx_size_q[i]);  // see RULE5
         end
         block_is_tx_o <= block_map_q;  // see RULE7
      end
   end

   // Magic number and overall health flag for the PPP engine.
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         magic_number_o <= '0;
         config_ok_o    <= 1'b0;
      end else begin
         magic_number_o <= {4{magic_q}};  // see RULE12
         config_ok_o    <= tx_aligned & total_ok & map_ok & tx_range_ok & rx_range_ok;
      end
   end

   // Echo request timer; runs only while the session is open.
   sbp_echo_timer #(
      .TICK_CYCLES (ECHO_TICK_CYCLES)
   ) u_echo (
      .core_clk_i (core_clk_i),
      .srst_i     (srst_i),
      .run_i      (ppp_link_open_i),
      .restart_i  (echo_wr),
      .interval_i (echo_interval_q),
      .echo_req_o (echo_req_o)
   );
endmodule : sbp_partition_regs

// ### include/sbp_regs.svh
// Offsets, reset values, fields and timing counts of the
// partition register bank.
// Assumes byte addressing on a 16-bit register port; included by sbp_pkg.
`ifndef SBP_REGS_SVH
`define SBP_REGS_SVH
// Port widths.
`define SBP_ADDR_W            10
`define SBP_DATA_W            16
// Register byte offsets.
`define SBP_OFS_TX_SIZE_01    10'h020
`define SBP_OFS_TX_SIZE_23    10'h022
`define SBP_OFS_TX_SIZE_45    10'h024
`define SBP_OFS_TX_SIZE_67    10'h026
`define SBP_OFS_RX_SIZE_01    10'h028
`define SBP_OFS_RX_SIZE_23    10'h02a
`define SBP_OFS_RX_SIZE_45    10'h02c
`define SBP_OFS_RX_SIZE_67    10'h02e
`define SBP_OFS_BLOCK_MAP     10'h030
`define SBP_OFS_AUTH_TYPE     10'h032
`define SBP_OFS_ECHO_INTERVAL 10'h036
`define SBP_OFS_MAGIC_SEED    10'h038
`define SBP_OFS_SESSION_ID    10'h03c
`define SBP_OFS_CFG_STATUS    10'h03e
// Reset values.
`define SBP_RST_SIZE_PAIR     16'h0808
`define SBP_RST_BLOCK_MAP     16'h00ff
`define SBP_RST_AUTH          16'h0000
`define SBP_RST_ECHO_INTERVAL 8'h28
`define SBP_RST_MAGIC         8'h00
`define SBP_RST_SESSION       16'h0000
// Authentication protocol codes.
`define SBP_AUTH_PAP          16'hc023
`define SBP_AUTH_CHAP         16'hc223
// Buffer geometry in kilobytes.
`define SBP_SIZE_MAX_KB       8'h40
`define SBP_BLOCK_KB          11'h008
`define SBP_TOTAL_KB          11'h080
// Status register bit positions.
`define SBP_STAT_TX_ALIGNED   0
`define SBP_STAT_TOTAL_OK     1
`define SBP_STAT_MAP_OK       2
`define SBP_STAT_RANGE_OK     3
// Echo tick length and the clock rate.
`define SBP_ECHO_TICK_MS      25
`define SBP_CLK_KHZ           200000
`endif

// ### include/sbp_pkg.sv
// Types of the partition register bank.
// Assumes sbp_regs.svh is on the include path.
`include "sbp_regs.svh"
package sbp_pkg;
   typedef logic [7:0]                 sbp_size_type;  // One socket size in KB.
   typedef logic [`SBP_DATA_W-1:0]     sbp_word_type;  // One register word.
   typedef logic [`SBP_ADDR_W-1:0]     sbp_addr_type;  // Byte address.
   typedef logic [10:0]                sbp_kb_sum_type; // Sum of eight sizes.
   // Authentication codes the PPP engine may report.
   typedef enum logic [15:0] {
      SBP_AUTH_NONE_CODE = `SBP_RST_AUTH,
      SBP_AUTH_PAP_CODE  = `SBP_AUTH_PAP,
      SBP_AUTH_CHAP_CODE = `SBP_AUTH_CHAP
   } sbp_auth_type;
endpackage : sbp_pkg

// ### hw/sbp_size_sum.sv
// Registered sum of eight size bytes, with a range check.
// Assumes sizes change only on core_clk_i.
`timescale 1ns/1ps
module sbp_size_sum (
   // Clock and reset.
   input  wire logic                    core_clk_i,
   input  wire logic                    srst_i,
   // Four size pairs, pair 0 in the low word.
   input  wire logic [63:0]             size_pairs_i,
   // Results.
   output sbp_pkg::sbp_kb_sum_type      sum_kb_o,
   output logic                         range_ok_o
);
   import sbp_pkg::*;

   // Adds all eight bytes; the order does not matter for a sum.
   function automatic sbp_kb_sum_type sbp_add_sizes(input logic [63:0] v);
      sbp_kb_sum_type acc;
      acc = '0;
      for (int i = 0; i < 8; i++) begin
         acc = acc + sbp_kb_sum_type'(v[8*i +: 8]);
      end
      return acc;
   endfunction : sbp_add_sizes

   // Every byte must lie between zero and sixty-four.
   function automatic logic sbp_all_in_range(input logic [63:0] v);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 8; i++) begin
         if (v[8*i +: 8] > `SBP_SIZE_MAX_KB) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction : sbp_all_in_range

   // The sum is registered to keep the adder tree off the read path.
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         sum_kb_o   <= 11'h040;
         range_ok_o <= 1'b1;
      end else begin
         sum_kb_o   <= sbp_add_sizes(size_pairs_i);
         range_ok_o <= sbp_all_in_range(size_pairs_i);
      end
   end
endmodule : sbp_size_sum

// ### hw/sbp_echo_timer.sv
// Echo request interval timer: a 25 ms prescaler and an interval counter.
// Assumes run_i and interval_i come from logic on core_clk_i.
`timescale 1ns/1ps
module sbp_echo_timer #(
   parameter int unsigned TICK_CYCLES = `SBP_ECHO_TICK_MS * `SBP_CLK_KHZ
) (
   // Clock and reset.
   input  wire logic       core_clk_i,
   input  wire logic       srst_i,
   // Control.
   input  wire logic       run_i,       // Session is open.
   input  wire logic       restart_i,   // Interval rewritten.
   input  wire logic [7:0] interval_i,  // Interval in ticks.
   // Result.
   output logic            echo_req_o   // One-cycle request pulse.
);
   import sbp_pkg::*;

   logic [22:0] pre_q;   // Cycles within one tick.
   logic [7:0]  tick_q;  // Ticks since last request.
   logic        tick;    // Last cycle of a tick.

   assign tick = (pre_q == 23'(TICK_CYCLES - 1));

   // Counters restart while the session is idle or on an interval
   // write; an interval of zero sends no requests.
   always_ff @(posedge core_clk_i) begin
      if (srst_i || !run_i || restart_i) begin
         pre_q      <= '0;
         tick_q     <= '0;
         echo_req_o <= 1'b0;
      end else begin
         pre_q      <= tick ? '0 : pre_q + 23'h000001;
         echo_req_o <= 1'b0;
         if (tick) begin
            if (interval_i != 8'h00 && tick_q + 8'h01 == interval_i) begin
               tick_q     <= '0;
               echo_req_o <= 1'b1;  // see RULE11
            end else begin
               tick_q <= tick_q + 8'h01;
            end
         end
      end
   end
endmodule : sbp_echo_timer

// ### test/sbp_partition_regs_sva.sv
// Port assertions of the partition register bank.
// Assumes binding to sbp_partition_regs; sees only its ports.
`timescale 1ns/1ps
module sbp_partition_regs_sva #(
   parameter int unsigned ECHO_TICK_CYCLES = 5000000  // Cycles in one echo tick.
) (
   // Clock and reset.
   input wire logic                  core_clk_i,
   input wire logic                  srst_i,
   // Register port.
   input wire sbp_pkg::sbp_addr_type reg_addr_i,
   input wire sbp_pkg::sbp_word_type reg_wdata_i,
   input wire logic                  reg_wr_i,
   input wire logic                  reg_rd_i,
   input wire sbp_pkg::sbp_word_type reg_rdata_o,
   // PPP engine reports.
   input wire logic                  ppp_auth_load_i,
   input wire sbp_pkg::sbp_word_type ppp_auth_code_i,
   input wire logic                  ppp_session_load_i,
   input wire sbp_pkg::sbp_word_type ppp_session_id_i,
   // Partition and PPP outputs.
   input wire logic [63:0]           tx_size_o,
   input wire logic [63:0]           rx_size_o,
   input wire logic [15:0]           block_is_tx_o,
   input wire logic [31:0]           magic_number_o,
   input wire logic                  echo_req_o
);
   import sbp_pkg::*;
   int unsigned gap_q;  // Cycles since the last echo pulse, saturating.

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (srst_i);

   // Saturates, so a long tick cannot wrap it.
   always_ff @(posedge core_clk_i) begin
      if (srst_i || echo_req_o) begin
         gap_q <= 1;
      end else if (gap_q < ECHO_TICK_CYCLES) begin
         gap_q <= gap_q + 1;
      end
   end

   property p_tx_pair;
      reg_wr_i && reg_addr_i == `SBP_OFS_TX_SIZE_01 |=> ##1
         tx_size_o[15:0] == {$past(reg_wdata_i[7:0], 2), $past(reg_wdata_i[15:8], 2)};
   endproperty
   a_tx_pair: assert property (p_tx_pair)
      else $error("tx pair wrong");
   property p_rx_pair;
      reg_wr_i && reg_addr_i == `SBP_OFS_RX_SIZE_67 |=> ##1
         rx_size_o[63:48] == {$past(reg_wdata_i[7:0], 2), $past(reg_wdata_i[15:8], 2)};
   endproperty
   a_rx_pair: assert property (p_rx_pair)
      else $error("rx pair wrong");
   property p_map;
      reg_wr_i && reg_addr_i == `SBP_OFS_BLOCK_MAP |=> ##1 block_is_tx_o == $past(reg_wdata_i, 2);
   endproperty
   a_map: assert property (p_map)
      else $error("map wrong");
   property p_magic;
      reg_wr_i && reg_addr_i == `SBP_OFS_MAGIC_SEED |=> ##1
         magic_number_o == {4{$past(reg_wdata_i[7:0], 2)}};
   endproperty
   a_magic: assert property (p_magic)
      else $error("magic wrong");
   property p_rst_sizes;
      $fell(srst_i) |-> tx_size_o == {8{8'h08}} && rx_size_o == {8{8'h08}};
   endproperty
   a_rst_sizes: assert property (p_rst_sizes)
      else $error("reset sizes");
   property p_rst_map;
      $fell(srst_i) |-> block_is_tx_o == 16'h00ff && magic_number_o == 32'h00000000;
   endproperty
   a_rst_map: assert property (p_rst_map)
      else $error("reset map");
   property p_auth;
      ppp_auth_load_i ##1 (reg_rd_i && reg_addr_i == `SBP_OFS_AUTH_TYPE && !ppp_auth_load_i)
         |=> reg_rdata_o == $past(ppp_auth_code_i, 2);
   endproperty
   a_auth: assert property (p_auth)
      else $error("auth wrong");
   property p_session;
      ppp_session_load_i ##1 (reg_rd_i && reg_addr_i == `SBP_OFS_SESSION_ID)
         ##0 !ppp_session_load_i |=> reg_rdata_o == $past(ppp_session_id_i, 2);
   endproperty
   a_session: assert property (p_session)
      else $error("session wrong");
   property p_interval;
      reg_wr_i && reg_addr_i == `SBP_OFS_ECHO_INTERVAL ##1
         (reg_rd_i && reg_addr_i == `SBP_OFS_ECHO_INTERVAL)
         |=> reg_rdata_o == {8'h00, $past(reg_wdata_i[7:0], 2)};
   endproperty
   a_interval: assert property (p_interval)
      else $error("interval wrong");
   property p_echo_gap;
      echo_req_o |-> gap_q >= ECHO_TICK_CYCLES;
   endproperty
   a_echo_gap: assert property (p_echo_gap)
      else $error("echo too soon");
endmodule : sbp_partition_regs_sva

bind sbp_partition_regs sbp_partition_regs_sva #(.ECHO_TICK_CYCLES(ECHO_TICK_CYCLES))
   sbp_partition_regs_sva_inst (.*);

// ### test/sbp_partition_regs_tb_top.sv
// Bench: a word model of the registers is checked at every read and output.
// Assumes the design is compiled first.
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin error_cnt++; \
   $display("Error %0t: got %h expected %h", $time, got, exp); end end
module sbp_partition_regs_tb_top;
   import sbp_pkg::*;
   localparam int TICK = 4;  // Short echo tick.
   logic          core_clk_i = 1'b0;
   logic          srst_i = 1'b1;
   sbp_addr_type  reg_addr_i = '0;
   sbp_word_type  reg_wdata_i = '0;
   logic          reg_wr_i = 1'b0;
   logic          reg_rd_i = 1'b0;
   sbp_word_type  reg_rdata_o;
   logic          ppp_auth_load_i = 1'b0;
   sbp_word_type  ppp_auth_code_i = '0;
   logic          ppp_session_load_i = 1'b0;
   sbp_word_type  ppp_session_id_i = '0;
   logic          ppp_link_open_i = 1'b0;
   logic [63:0]   tx_size_o;
   logic [63:0]   rx_size_o;
   logic [15:0]   block_is_tx_o;
   logic [31:0]   magic_number_o;
   logic          echo_req_o;
   logic          config_ok_o;
   int            error_cnt = 0;
   int            checked = 0;
   int            mdl [int];      // Register words keyed by byte offset.
   int            exp_rd = 0;     // Read data due in the next cycle.
   logic          rd_due = 1'b0;  // A read was taken at the last edge.
   int            pulses = 0;     // Echo pulses seen.
   int            gap = 0;        // Cycles since the last echo pulse.
   int            last_gap = 0;   // Spacing of the last two pulses.
   logic [31:0]   seed = 32'h10e08c73;
   // Mapped words, then three unmapped ones.
   sbp_addr_type  regs [16] = '{10'h020, 10'h022, 10'h024, 10'h026, 10'h028,
      10'h02a, 10'h02c, 10'h02e, 10'h030, 10'h032, 10'h036, 10'h038, 10'h03c,
      10'h034, 10'h03a, 10'h100};
   // A consistent partition: 72 KB transmit, 56 KB receive, nine blocks.
   sbp_word_type  part [9] = '{16'h0410, 16'h0114, 16'h0007, 16'h0c0c, 16'h1103,
      16'h0510, 16'h0304, 16'h0404, 16'h01ff};

   sbp_partition_regs #(.ECHO_TICK_CYCLES(TICK)) sbp_partition_regs_inst (.*);

   // A 200 MHz clock.
   always #2.5 core_clk_i = ~core_clk_i;

   // Xorshift: the same traffic every run.
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   // Reset values of the model.
   task automatic mdl_reset();
      foreach (regs[i]) if (i < 13) mdl[int'(regs[i])] = i < 8 ? 32'h0808 : 0;
      mdl[32'h030] = 32'h00ff;
      mdl[32'h036] = 32'h0028;
   endtask : mdl_reset

   // Sampled before the edge lands: read data belong to the last strobe.
   always @(posedge core_clk_i) begin
      if (echo_req_o) begin
         pulses <= pulses + 1;
         last_gap <= gap;
         gap <= 1;
      end else begin
         gap <= gap + 1;
      end
      if (srst_i) begin
         mdl_reset();
         rd_due = 1'b0;
      end else begin
         `CHK(reg_rdata_o, rd_due ? 16'(exp_rd) : 16'h0000)
         rd_due = reg_rd_i;
         exp_rd = mdl.exists(int'(reg_addr_i)) ? mdl[int'(reg_addr_i)] : 0;
         // Read-only words ignore writes.
         if (reg_wr_i && mdl.exists(int'(reg_addr_i)) && !(reg_addr_i inside {10'h032, 10'h03c}))
            mdl[int'(reg_addr_i)] = (reg_addr_i inside {10'h036, 10'h038}) ?
               int'(reg_wdata_i[7:0]) : int'(reg_wdata_i);
         if (ppp_auth_load_i) mdl[32'h032] = int'(ppp_auth_code_i);
         if (ppp_session_load_i) mdl[32'h03c] = int'(ppp_session_id_i);
      end
   end

   // One bus cycle; strobes stay as set until the next call.
   task automatic cyc(input logic w, input logic r, input sbp_addr_type a, input sbp_word_type d);
      reg_wr_i <= w;
      reg_rd_i <= r;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge core_clk_i);
   endtask : cyc

   task automatic wr(input sbp_addr_type a, input sbp_word_type d);
      cyc(1'b1, 1'b0, a, d);
   endtask : wr

   task automatic rd(input sbp_addr_type a);
      cyc(1'b0, 1'b1, a, 16'h0000);
   endtask : rd

   task automatic idle(input int n);
      repeat (n) cyc(1'b0, 1'b0, 10'h000, 16'h0000);
   endtask : idle

   // Outputs lag a write by two edges, so callers idle first.
   task automatic chk_outs();
      logic [63:0] tx;
      logic [63:0] rx;
      for (int n = 0; n < 8; n++) begin
         tx[8*n+:8] = 8'(mdl[32'h020 + 2 * (n / 2)] >> (n % 2 ? 0 : 8));
         rx[8*n+:8] = 8'(mdl[32'h028 + 2 * (n / 2)] >> (n % 2 ? 0 : 8));
      end
      `CHK(tx_size_o, tx)
      `CHK(rx_size_o, rx)
      `CHK(block_is_tx_o, 16'(mdl[32'h030]))
      `CHK(magic_number_o, {4{8'(mdl[32'h038])}})
   endtask : chk_outs

   // Sets an interval, opens the link, measures pulse spacing.
   task automatic echo(input int iv);
      int p0;
      wr(10'h036, 16'(iv));
      ppp_link_open_i <= 1'b1;
      p0 = pulses;
      idle(3 * iv * TICK + 12);
      if (iv == 0) `CHK(pulses, p0)
      else `CHK(last_gap, iv * TICK)
      ppp_link_open_i <= 1'b0;
      idle(2);
   endtask : echo

   task automatic complete_run();
      $display("Mismatches %0d, comparisons %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : complete_run

   initial begin
      logic [31:0] r;
      sbp_addr_type a;
      int p0;
      repeat (16) @(posedge core_clk_i);
      srst_i <= 1'b0;
      foreach (regs[i]) rd(regs[i]);
      idle(3);
      chk_outs();
      // Size bytes at both ends of their range.
      for (int i = 0; i < 8; i++) begin
         wr(regs[i], i % 2 ? 16'h4000 : 16'h0040);
         rd(regs[i]);
      end
      idle(3);
      chk_outs();
      foreach (part[i]) wr(regs[i], part[i]);
      idle(5);
      `CHK(config_ok_o, 1'b1)
      foreach (regs[i]) if (i > 8) wr(regs[i], 16'hffff);
      foreach (regs[i]) rd(regs[i]);
      wr(10'h038, 16'h5a01);
      idle(3);
      chk_outs();
      for (int i = 0; i < 2; i++) begin
         ppp_auth_load_i <= 1'b1;
         ppp_auth_code_i <= i ? SBP_AUTH_CHAP_CODE : SBP_AUTH_PAP_CODE;
         ppp_session_load_i <= 1'b1;
         ppp_session_id_i <= 16'h0017 + 16'(i);
         idle(1);
         ppp_auth_load_i <= 1'b0;
         ppp_session_load_i <= 1'b0;
         rd(10'h032);
         rd(10'h03c);
      end
      foreach (regs[i]) if (i == 8) for (int m = 0; m < 3; m++) begin
         wr(regs[i], m == 0 ? 16'hffff : (m == 1 ? 16'h0000 : 16'h8001));
         idle(3);
         chk_outs();
      end
      echo(1);
      echo(2);
      echo(0);
      echo(255);
      p0 = pulses;
      idle(40);
      `CHK(pulses, p0)
      for (int i = 0; i < 400; i++) begin
         r = xs();
         a = r[6] ? {5'b00001, r[4:1], 1'b0} : {3'b000, r[5:0], 1'b0};
         if (a == 10'h03e) a = 10'h034;
         ppp_auth_load_i <= r[10] & r[11];
         ppp_auth_code_i <= r[12] ? SBP_AUTH_CHAP_CODE : SBP_AUTH_PAP_CODE;
         ppp_session_load_i <= r[13] & r[14];
         ppp_session_id_i <= r[31:16];
         ppp_link_open_i <= r[15];
         cyc(r[9:8] == 2'b00, r[8], a, r[31:16]);
      end
      ppp_auth_load_i <= 1'b0;
      ppp_session_load_i <= 1'b0;
      idle(3);
      chk_outs();
      srst_i <= 1'b1;
      idle(2);
      srst_i <= 1'b0;
      foreach (regs[i]) rd(regs[i]);
      idle(3);
      chk_outs();
      complete_run();
   end

   // Watchdog; the run needs about 3700 cycles.
   initial begin
      repeat (20000) @(posedge core_clk_i);
      error_cnt++;
      complete_run();
   end
endmodule : sbp_partition_regs_tb_top
